// File: lsr_regbank.v
// two-wire serial slave and register bank of a two-channel light sensor
`include "lsr_map.vh"
`default_nettype none

module lsr_regbank #(
	parameter [6:0] SLAVE_ADDR = 7'h29,
	// identification value is arbitrary
	parameter [7:0] PART_ID    = 8'h5A
) (
	// clock and reset
	input  wire        ref_clk_i,
	input  wire        rst_b_i,
	// two-wire serial pins
	input  wire        scl_i,
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe_o,
	// conversion results from the converter logic
	input  wire [15:0] ch0_result_i,
	input  wire [15:0] ch1_result_i,
	// control towards the converter and interrupt logic
	output wire        power_on_o,
	output wire        gain_high_o,
	output wire [1:0]  integ_sel_o,
	output wire        manual_integrate_o,
	output wire [15:0] low_thresh_o,
	output wire [15:0] high_thresh_o,
	output wire [7:0]  int_config_o,
	output wire        int_clear_o
);

	// ----------------------------------------------------------------
	// fsm states
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_ADDR  = 3'h1;
	localparam [2:0] ST_ACK   = 3'h2;
	localparam [2:0] ST_WR    = 3'h3;
	localparam [2:0] ST_RD    = 3'h4;
	localparam [2:0] ST_RACK  = 3'h5;
	localparam [2:0] ST_RLOAD = 3'h6;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// bit 0 is the serial clock pin, bit 1 the serial data pin
	wire [1:0] pin_raw = {sda_i, scl_i};
	reg  [1:0] pin_meta_q;
	reg  [1:0] pin_sync_q;
	reg  [1:0] pin_prev_q;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
			// both pins idle high: a high reset value avoids a false edge after reset
			always @(posedge ref_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					pin_meta_q[gi] <= 1'b1;
					pin_sync_q[gi] <= 1'b1;
					pin_prev_q[gi] <= 1'b1;
				end else begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
					pin_prev_q[gi] <= pin_sync_q[gi];
				end
			end
		end
	endgenerate

	wire scl_s    = pin_sync_q[0];
	wire sda_s    = pin_sync_q[1];
	wire scl_prev = pin_prev_q[0];
	wire sda_prev = pin_prev_q[1];
	wire scl_rise = scl_s & ~scl_prev;
	wire scl_fall = ~scl_s & scl_prev;
	// start and stop are sda edges while scl stays high
	wire bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
	wire bus_stop  = scl_s & scl_prev & ~sda_prev & sda_s;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [2:0]  state_q;
	reg [3:0]  bit_cnt_q;
	reg [7:0]  shift_q;
	reg        rd_mode_q;
	reg        byte_idx_q;
	reg        sda_oe_q;
	reg        sda_out_q;
	reg [7:0]  cmd_q;
	reg [7:0]  power_q;
	reg [7:0]  timing_q;
	reg [7:0]  thr_ll_q;
	reg [7:0]  thr_lh_q;
	reg [7:0]  thr_hl_q;
	reg [7:0]  thr_hh_q;
	reg [7:0]  int_cfg_q;
	reg        power_on_q;
	reg        manual_q;
	reg        int_clear_q;

	wire [3:0] ptr_w  = cmd_q[`LSR_CMD_PTR_MSB:`LSR_CMD_PTR_LSB];
	wire       word_w = cmd_q[`LSR_CMD_WORD_BIT];
	wire [3:0] data_addr = ptr_w + {3'h0, byte_idx_q};
	wire [7:0] rx_byte   = {shift_q[6:0], sda_s};
	// eighth bit taken: the clock fall that opens the acknowledge slot
	wire       byte_done = scl_fall & (bit_cnt_q == 4'h8);

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------
	reg [7:0] rd_data;

	always @* begin
		rd_data = 8'h00;
		case (data_addr)
			`LSR_OFS_POWER_CONTROL: rd_data = power_q;
			`LSR_OFS_GAIN_INTEG:    rd_data = timing_q;
			`LSR_OFS_LOW_THR_LOW:   rd_data = thr_ll_q;
			`LSR_OFS_LOW_THR_HIGH:  rd_data = thr_lh_q;
			`LSR_OFS_HIGH_THR_LOW:  rd_data = thr_hl_q;
			`LSR_OFS_HIGH_THR_HIGH: rd_data = thr_hh_q;
			`LSR_OFS_INT_CONFIG:    rd_data = int_cfg_q;
			`LSR_OFS_PART_ID:       rd_data = PART_ID;
			`LSR_OFS_CH0_LOW:       rd_data = ch0_result_i[7:0];
			`LSR_OFS_CH0_HIGH:      rd_data = ch0_result_i[15:8];
			`LSR_OFS_CH1_LOW:       rd_data = ch1_result_i[7:0];
			`LSR_OFS_CH1_HIGH:      rd_data = ch1_result_i[15:8];
			default:                rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// serial fsm and register writes
	// ----------------------------------------------------------------
	// all pin timing is seen through the synchroniser, about three clocks late;
	// the serial clock phases must therefore stay well above three clock periods.
	// a start or stop wins over any state so that a cut frame never hangs the fsm.
	// results are read live when a byte is loaded: a word read of a channel is
	// only coherent if the converter holds its value for the whole transfer.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q     <= ST_IDLE;
			bit_cnt_q   <= 4'h0;
			shift_q     <= 8'h00;
			rd_mode_q   <= 1'b0;
			byte_idx_q  <= 1'b0;
			sda_oe_q    <= 1'b0;
			sda_out_q   <= 1'b0;
			cmd_q       <= `LSR_RST_CMD;
			power_q     <= `LSR_RST_POWER;
			timing_q    <= `LSR_RST_TIMING;
			thr_ll_q    <= `LSR_RST_THR;
			thr_lh_q    <= `LSR_RST_THR;
			thr_hl_q    <= `LSR_RST_THR;
			thr_hh_q    <= `LSR_RST_THR;
			int_cfg_q   <= `LSR_RST_INT_CFG;
			power_on_q  <= 1'b0;
			manual_q    <= 1'b0;
			int_clear_q <= 1'b0;
		end else begin
			int_clear_q <= 1'b0;
			manual_q    <= (timing_q[`LSR_TIM_INTEG_MSB:`LSR_TIM_INTEG_LSB] == `LSR_INTEG_MANUAL)
				& timing_q[`LSR_TIM_MANUAL_BIT];
			power_on_q  <= (power_q[`LSR_PWR_MSB:`LSR_PWR_LSB] == `LSR_PWR_UP);
			if (bus_start) begin
				state_q    <= ST_ADDR;
				bit_cnt_q  <= 4'h0;
				byte_idx_q <= 1'b0;
				sda_oe_q   <= 1'b0;
			end else if (bus_stop) begin
				state_q  <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						sda_oe_q <= 1'b0;
					end
					ST_ADDR: begin
						if (scl_rise) begin
							shift_q   <= rx_byte;
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (byte_done) begin
							if (shift_q[7:1] == SLAVE_ADDR) begin
								rd_mode_q <= shift_q[0];
								sda_oe_q  <= 1'b1;
								state_q   <= ST_ACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_ACK: begin
						// ack bit ends on the falling edge of its clock
						if (scl_fall) begin
							bit_cnt_q <= 4'h0;
							if (rd_mode_q) begin
								shift_q  <= rd_data;
								sda_oe_q <= ~rd_data[7];
								state_q  <= ST_RD;
							end else begin
								sda_oe_q <= 1'b0;
								state_q  <= ST_WR;
							end
						end
					end
					ST_WR: begin
						if (scl_rise) begin
							shift_q   <= rx_byte;
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (byte_done) begin
							// every byte addressed to us is acknowledged, ignored or not
							sda_oe_q <= 1'b1;
							state_q  <= ST_ACK;
							if (shift_q[`LSR_CMD_SEL_BIT]) begin
								cmd_q       <= {shift_q[7], 1'b0, shift_q[5:0]};
								int_clear_q <= shift_q[`LSR_CMD_CLEAR_BIT];
								byte_idx_q  <= 1'b0;
							end else begin
								if (word_w)
									byte_idx_q <= 1'b1;
								case (data_addr)
									`LSR_OFS_POWER_CONTROL:
										power_q <= {6'h00, shift_q[`LSR_PWR_MSB:`LSR_PWR_LSB]};
									`LSR_OFS_GAIN_INTEG:
										timing_q <= shift_q & `LSR_TIM_MASK;
									`LSR_OFS_LOW_THR_LOW:   thr_ll_q <= shift_q;
									`LSR_OFS_LOW_THR_HIGH:  thr_lh_q <= shift_q;
									`LSR_OFS_HIGH_THR_LOW:  thr_hl_q <= shift_q;
									`LSR_OFS_HIGH_THR_HIGH: thr_hh_q <= shift_q;
									`LSR_OFS_INT_CONFIG:
										int_cfg_q <= shift_q & `LSR_INT_CFG_MASK;
									default: begin
									end
								endcase
							end
						end
					end
					ST_RD: begin
						if (scl_fall) begin
							if (bit_cnt_q == 4'h7) begin
								sda_oe_q <= 1'b0;
								state_q  <= ST_RACK;
								if (word_w)
									byte_idx_q <= 1'b1;
							end else begin
								shift_q   <= {shift_q[6:0], 1'b0};
								sda_oe_q  <= ~shift_q[6];
								bit_cnt_q <= bit_cnt_q + 4'h1;
							end
						end
					end
					ST_RACK: begin
						// a not-acknowledge ends the read
						if (scl_rise)
							state_q <= sda_s ? ST_IDLE : ST_RLOAD;
					end
					ST_RLOAD: begin
						if (scl_fall) begin
							bit_cnt_q <= 4'h0;
							shift_q   <= rd_data;
							sda_oe_q  <= ~rd_data[7];
							state_q   <= ST_RD;
						end
					end
					default: begin
						state_q  <= ST_IDLE;
						sda_oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// open drain: the pin only ever pulls low, so the data register stays zero
	// and only the enable moves; driving a one would fight the pull-up
	assign sda_o              = sda_out_q;
	assign sda_oe_o           = sda_oe_q;
	// power and manual strobes are one clock behind their register fields
	assign power_on_o         = power_on_q;
	assign gain_high_o        = timing_q[`LSR_TIM_GAIN_BIT];
	assign integ_sel_o        = timing_q[`LSR_TIM_INTEG_MSB:`LSR_TIM_INTEG_LSB];
	assign manual_integrate_o = manual_q;
	assign low_thresh_o       = {thr_lh_q, thr_ll_q};
	assign high_thresh_o      = {thr_hh_q, thr_hl_q};
	assign int_config_o       = int_cfg_q;
	assign int_clear_o        = int_clear_q;

endmodule // lsr_regbank

`default_nettype wire

// File: lsr_map.vh
// register offsets, field positions and reset values of the light sensor register bank
`ifndef LSR_MAP_VH
`define LSR_MAP_VH

// ----------------------------------------------------------------
// register offsets (four-bit pointer values)
// ----------------------------------------------------------------
`define LSR_OFS_POWER_CONTROL    4'h0
`define LSR_OFS_GAIN_INTEG       4'h1
`define LSR_OFS_LOW_THR_LOW      4'h2
`define LSR_OFS_LOW_THR_HIGH     4'h3
`define LSR_OFS_HIGH_THR_LOW     4'h4
`define LSR_OFS_HIGH_THR_HIGH    4'h5
`define LSR_OFS_INT_CONFIG       4'h6
`define LSR_OFS_RSVD_7           4'h7
`define LSR_OFS_FACTORY_TEST     4'h8
`define LSR_OFS_RSVD_9           4'h9
`define LSR_OFS_PART_ID          4'hA
`define LSR_OFS_RSVD_B           4'hB
`define LSR_OFS_CH0_LOW          4'hC
`define LSR_OFS_CH0_HIGH         4'hD
`define LSR_OFS_CH1_LOW          4'hE
`define LSR_OFS_CH1_HIGH         4'hF

// ----------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------
`define LSR_CMD_SEL_BIT          7
`define LSR_CMD_CLEAR_BIT        6
`define LSR_CMD_WORD_BIT         5
`define LSR_CMD_PTR_MSB          3
`define LSR_CMD_PTR_LSB          0

// ----------------------------------------------------------------
// power control and timing fields
// ----------------------------------------------------------------
`define LSR_PWR_MSB              1
`define LSR_PWR_LSB              0
`define LSR_PWR_UP               2'h3
`define LSR_TIM_GAIN_BIT         4
`define LSR_TIM_MANUAL_BIT       3
`define LSR_TIM_INTEG_MSB        1
`define LSR_TIM_INTEG_LSB        0
`define LSR_INTEG_MANUAL         2'h3
// timing keeps gain, manual and integration bits; reserved bits read zero
`define LSR_TIM_MASK             8'h1B
`define LSR_INT_CFG_MASK         8'h3F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LSR_RST_CMD              8'h00
`define LSR_RST_POWER            8'h00
`define LSR_RST_TIMING           8'h02
`define LSR_RST_THR              8'h00
`define LSR_RST_INT_CFG          8'h00

`endif

// File: lsr_regbank_asserts.sv
// property checker for the light sensor register bank ports
`default_nettype none
module lsr_regbank_asserts (
	// clock, reset and serial pins
	input wire logic        ref_clk_i,
	input wire logic        rst_b_i,
	input wire logic        scl_i,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_o,
	// results and controls
	input wire logic [15:0] ch0_result_i,
	input wire logic [15:0] ch1_result_i,
	input wire logic        power_on_o,
	input wire logic        gain_high_o,
	input wire logic [1:0]  integ_sel_o,
	input wire logic        manual_integrate_o,
	input wire logic [15:0] low_thresh_o,
	input wire logic [15:0] high_thresh_o,
	input wire logic [7:0]  int_config_o,
	input wire logic        int_clear_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	a_clear_one_cycle: assert property (int_clear_o |=> !int_clear_o)
		else $error("clear pulse too long");
	a_clear_scl_low: assert property (int_clear_o |-> !scl_i)
		else $error("clear outside byte end");
	a_timing_reset: assert property ($rose(rst_b_i) |-> integ_sel_o == 2'h2 && !gain_high_o)
		else $error("timing reset value wrong");
	a_power_reset: assert property ($rose(rst_b_i) |-> !power_on_o && !sda_oe_o)
		else $error("power reset value wrong");
	// two cycles cover the extra stage on the manual output
	a_manual_gated: assert property ((integ_sel_o != 2'h3) [*2] |-> !manual_integrate_o)
		else $error("manual start outside manual mode");
	a_power_at_byte: assert property ($changed(power_on_o) |-> !scl_i)
		else $error("power change off byte end");
	a_thresh_at_byte: assert property ($changed({low_thresh_o, high_thresh_o}) |-> !scl_i)
		else $error("threshold change off byte end");
	a_timing_at_byte: assert property ($changed({gain_high_o, integ_sel_o}) |-> !scl_i)
		else $error("timing change off byte end");
	a_cfg_rsvd_zero: assert property (int_config_o[7:6] == 2'h0)
		else $error("interrupt config reserved bits set");
	a_pin_at_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data pin moved with clock high");
	a_sda_open_drain: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	c_clear: cover property (int_clear_o);
	c_manual: cover property (manual_integrate_o);
	c_power: cover property (power_on_o);
endmodule // lsr_regbank_asserts

bind lsr_regbank lsr_regbank_asserts u_chk (.ref_clk_i, .rst_b_i, .scl_i, .sda_i, .sda_o,
	.sda_oe_o, .ch0_result_i, .ch1_result_i, .power_on_o, .gain_high_o, .integ_sel_o,
	.manual_integrate_o, .low_thresh_o, .high_thresh_o, .int_config_o, .int_clear_o);
`default_nettype wire

// File: lsr_host.sv
// two-wire bus host model driving the sensor pins
`default_nettype none
module lsr_host (
	// bus pins
	output var logic  scl_o,
	output var logic  sda_low_o,
	input  wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// quarter of the 125 ns serial clock; clock stands high between frames
	localparam realtime Q = 31.25;
	int nacks = 0;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic bit_io(input logic b, output logic s);
		sda_low_o = !b;
		#Q scl_o = 1'b1;
		#Q s = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	task automatic start;
		sda_low_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	task automatic stop;
		sda_low_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b0;
		#Q;
	endtask
	// FF means receive: the line is released for the device
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, a);
		if (d != 8'hFF && a !== 1'b0)
			nacks++;
	endtask
endmodule // lsr_host
`default_nettype wire

// File: lsr_regbank_tb.sv
// self-checking bench of the light sensor register bank
`default_nettype none
module lsr_regbank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] ADR = 7'h39;
	// identification value is arbitrary
	localparam logic [7:0] IDV = 8'hA5;
	logic        ref_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        scl_i, sda_low, sda_o, sda_oe_o, power_on_o, gain_high_o;
	logic        manual_integrate_o, int_clear_o;
	logic [1:0]  integ_sel_o;
	logic [15:0] ch0_result_i = 16'h0000, ch1_result_i = 16'h0000;
	logic [15:0] low_thresh_o, high_thresh_o;
	logic [7:0]  int_config_o;
	logic [31:0] r;
	logic [7:0]  rq;
	wire logic   sda_i = !(sda_low | sda_oe_o);
	int          failures = 0, check_count = 0, clears = 0, seed = 32'hEE94;
	int          mem [16] = '{default: 0};
	lsr_host host (.scl_o(scl_i), .sda_low_o(sda_low), .sda_i(sda_i));
	lsr_regbank #(.SLAVE_ADDR(ADR), .PART_ID(IDV)) dut (.ref_clk_i, .rst_b_i, .scl_i, .sda_i,
		.sda_o, .sda_oe_o, .ch0_result_i, .ch1_result_i, .power_on_o, .gain_high_o,
		.integ_sel_o, .manual_integrate_o, .low_thresh_o, .high_thresh_o, .int_config_o,
		.int_clear_o);
	initial forever #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (int_clear_o === 1'b1) clears <= clears + 1;
	// ----------------------------------------------------------------
	// model and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		check_count++;
		if (a !== e) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, a, e);
		end
	endtask
	function automatic logic [7:0] exp_rd(input int p);
		case (p)
			0: return mem[0] & 8'h03;
			1: return mem[1] & 8'h1B;
			2, 3, 4, 5: return mem[p];
			6: return mem[6] & 8'h3F;
			10: return IDV;
			12: return ch0_result_i[7:0];
			13: return ch0_result_i[15:8];
			14: return ch1_result_i[7:0];
			15: return ch1_result_i[15:8];
			default: return 8'h00;
		endcase
	endfunction
	// a byte with msb set is taken as a new command anywhere
	task automatic wr(input logic [23:0] d, input int n);
		int p, k;
		logic w;
		logic [7:0] b, q;
		host.start();
		host.xfer({ADR, 1'b0}, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			b = d[8*i +: 8];
			host.xfer(b, 1'b1, q);
			if (b[7]) begin
				p = b[3:0];
				w = b[5];
				k = 0;
			end else begin
				mem[(p + k) % 16] = b;
				k = w;
			end
		end
		host.stop();
	endtask
	task automatic rd(input logic [7:0] c, input int n);
		logic [7:0] q;
		host.start();
		if (c[7]) begin
			host.xfer({ADR, 1'b0}, 1'b1, q);
			host.xfer(c, 1'b1, q);
			host.start();
		end
		host.xfer({ADR, 1'b1}, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			host.xfer(8'hFF, i == n - 1, q);
			chk(q, exp_rd((c[3:0] + (i > 0 && c[5])) % 16));
		end
		host.stop();
	endtask
	task automatic outs;
		chk(low_thresh_o, {mem[3][7:0], mem[2][7:0]});
		chk(high_thresh_o, {mem[5][7:0], mem[4][7:0]});
		chk(int_config_o, mem[6] & 8'h3F);
		chk(power_on_o, mem[0][1:0] == 2'h3);
		chk({gain_high_o, integ_sel_o}, {mem[1][4], mem[1][1:0]});
		chk(manual_integrate_o, mem[1][3] && mem[1][1:0] == 2'h3);
	endtask
	task automatic results;
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mem[1] = 2;
		repeat (20) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		outs();
		rd(8'h00, 1);
		wr(24'h0380, 2);
		rd(8'h80, 1);
		for (int t = 0; t < 16; t++) begin
			wr({8'h00, 3'h0, t[3:2], 1'b0, t[1:0], 8'h81}, 2);
			outs();
		end
		for (int j = 2; j < 6; j += 2) begin
			r = $random(seed);
			wr({r[15:0] & 16'h7F7F, 4'hA, j[3:0]}, 3);
			outs();
		end
		r = $random(seed);
		wr({8'h00, r[7:0] & 8'h3F, 8'h86}, 2);
		wr({8'h21, 8'h83, 8'h80}, 3);
		outs();
		for (int p = 7; p < 16; p++)
			wr({8'h00, 8'h5A, 4'h8, p[3:0]}, 2);
		@(posedge ref_clk_i);
		r = $random(seed);
		ch0_result_i <= r[15:0];
		ch1_result_i <= r[31:16];
		@(posedge ref_clk_i);
		for (int p = 0; p < 16; p++)
			rd({4'h8, p[3:0]}, 1);
		rd(8'hAC, 2);
		rd(8'hAE, 2);
		rd(8'hA2, 2);
		wr(24'h0000C0, 1);
		chk(clears, 1);
		rd(8'h00, 1);
		chk(host.nacks, 0);
		// a foreign address is refused: no ack, and the data byte changes nothing
		host.start();
		host.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, rq);
		host.xfer(8'h00, 1'b1, rq);
		host.stop();
		chk(host.nacks, 2);
		outs();
		results();
	end
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		failures++;
		results();
	end
endmodule // lsr_regbank_tb
`default_nettype wire
